// ---- rtl/avmm_front.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pattern_unit_regs.svh"

module avmm_front (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus request
    input wire logic read,
    input wire logic write,
    input wire logic [7:0] rd_value,
    // Bus answer
    output logic waitrequest,
    output logic [31:0] readdata,
    // Commit strobe, high in the cycle the write takes effect
    output logic wr_commit
);

    pattern_unit_pkg::bus_state_t state_r;
    pattern_unit_pkg::bus_state_t state_nxt;
    logic [31:0] readdata_r;
    logic waitrequest_r;
    wire logic req;
    wire logic in_ack;

    assign req = read | write;
    assign in_ack = (state_r == pattern_unit_pkg::BUS_ACK);

    always_comb begin
        case (state_r)
            pattern_unit_pkg::BUS_IDLE: begin
                state_nxt = req ? pattern_unit_pkg::BUS_ACK : pattern_unit_pkg::BUS_IDLE;
            end
            default: begin
                state_nxt = pattern_unit_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= pattern_unit_pkg::BUS_IDLE;
            waitrequest_r <= 1'b1;
            readdata_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            // Registered from the next state so the answer leaves the block
            // straight from a flop without costing an extra wait cycle.
            waitrequest_r <= (state_nxt != pattern_unit_pkg::BUS_ACK);
            if (read && !in_ack) begin
                readdata_r <= {24'h00_0000, rd_value};
            end
        end
    end

    assign waitrequest = waitrequest_r;
    assign readdata = readdata_r;
    assign wr_commit = write && in_ack;

endmodule
`default_nettype wire

// ---- rtl/pattern_group.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pattern_unit_regs.svh"

module pattern_group (
    // Timer compare match pulses, one per channel
    input wire logic [2:0] cm_a,
    input wire logic [2:0] cm_b,
    // Group settings
    input wire logic [1:0] trig_sel,
    input wire logic non_overlap,
    input wire logic [3:0] enable,
    input wire logic [3:0] next_data,
    // Per-bit load strobe for the port latch
    output logic [3:0] load
);

    wire logic hit_a;
    wire logic hit_b;
    wire logic [3:0] load_normal;
    wire logic [3:0] load_nonovl;

    // Channel 2 answers both upper codes so that the all-ones reset is valid.
    assign hit_a = (trig_sel == pattern_unit_pkg::TRIG_CH0) ? cm_a[0] :
                   (trig_sel == pattern_unit_pkg::TRIG_CH1) ? cm_a[1] : cm_a[2];
    assign hit_b = (trig_sel == pattern_unit_pkg::TRIG_CH0) ? cm_b[0] :
                   (trig_sel == pattern_unit_pkg::TRIG_CH1) ? cm_b[1] : cm_b[2];

    assign load_normal = enable & {`GROUP_W{hit_a}};
    // Rising bits wait for compare A, falling bits take compare B, so the
    // gap between the two events is the margin between pulses.
    assign load_nonovl = enable & (({`GROUP_W{hit_a}} & next_data) |
                                   ({`GROUP_W{hit_b}} & ~next_data));
    assign load = non_overlap ? load_nonovl : load_normal;

endmodule
`default_nettype wire

// ---- rtl/pattern_unit_pkg.sv ----
`default_nettype none
package pattern_unit_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;

    typedef enum logic [1:0] {
        TRIG_CH0 = 2'b00,
        TRIG_CH1 = 2'b01,
        TRIG_CH2 = 2'b10,
        TRIG_CH2_ALT = 2'b11
    } trig_sel_t;

endpackage
`default_nettype wire

// ---- rtl/pattern_unit_regs.svh ----
`ifndef PATTERN_UNIT_REGS_SVH
`define PATTERN_UNIT_REGS_SVH

// ****************************************************************
// Register indices; the byte address on the bus is four times these.
// ****************************************************************
`define IDX_PORT_A_DIRECTION 20'hEE009
`define IDX_PORT_B_DIRECTION 20'hEE00A
`define IDX_PATTERN_OUTPUT_MODE 20'hFFFA0
`define IDX_PATTERN_TRIGGER_CONTROL 20'hFFFA1
`define IDX_NEXT_ENABLE_HIGH_GROUPS 20'hFFFA2
`define IDX_NEXT_ENABLE_LOW_GROUPS 20'hFFFA3
`define IDX_NEXT_DATA_HIGH_GROUPS 20'hFFFA4
`define IDX_NEXT_DATA_LOW_GROUPS 20'hFFFA5
`define IDX_NEXT_DATA_HIGH_SPLIT 20'hFFFA6
`define IDX_NEXT_DATA_LOW_SPLIT 20'hFFFA7
`define IDX_PORT_A_OUTPUT_LATCH 20'hFFFD9
`define IDX_PORT_B_OUTPUT_LATCH 20'hFFFDA

// ****************************************************************
// Address field of the bus: index bits above the byte lane bits.
// ****************************************************************
`define IDX_LSB 2
`define IDX_MSB 21

// ****************************************************************
// Reset values and fixed read values.
// ****************************************************************
`define RST_DIRECTION 8'h00
`define RST_MODE 8'hF0
`define RST_TRIGGER_CONTROL 8'hFF
`define RST_NEXT_ENABLE 8'h00
`define RST_NEXT_DATA 8'h00
`define RST_OUTPUT_LATCH 8'h00
`define RESERVED_NIBBLE 4'hF
`define RESERVED_BYTE 8'hFF
`define MODE_RESERVED_BITS 4'hF

// ****************************************************************
// Field layout: trigger select is two bits per group, group g at 2g.
// Non-overlap enable for group g is mode bit g.
// ****************************************************************
`define TRIG_SEL_W 2
`define GROUP_COUNT 4
`define GROUP_W 4

`endif

// ---- rtl/timing_pattern_unit.sv ----
// Behaviour
// - Pattern outputs form four independent 4-bit groups that may run at the same time.
// - Up to 16 output bits, each enabled or disabled for pattern output on its own.
// - Each group picks its update trigger from the compare matches of three timer channels.
// - A non-overlap mode puts a margin between successive pulses.
// - Outputs 0-3, 4-7, 8-11 and 12-15 belong to groups 0, 1, 2 and 3.
// - Port A latch holds groups 0 and 1, port B latch holds groups 2 and 3.
// - Latch bits enabled for pattern output are read-only; the rest stay writable.
// - Both direction registers are 8-bit, write-only and reset to zero.
// - Mode resets to F0, trigger control to FF, enables, next data and latches to zero.
// - Low next data sits whole at A5 with equal trigger codes, else group 1 at A5, group 0 at A7.
// - High next data sits whole at A4 with equal trigger codes, else group 3 at A4, group 2 at A6.
// - Decoding compares only the low 20 bits of the register index.
// - On its trigger, a group copies each enabled next data bit into its latch bit.
// - A disabled bit is not copied and its output stays unchanged.
// - Reserved next data positions ignore writes and read back as 1.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "pattern_unit_regs.svh"

module timing_pattern_unit (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Avalon-MM register slave
    input wire logic [31:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // Timer compare match pulses, channels 0 to 2
    input wire logic [2:0] CM_A,
    input wire logic [2:0] CM_B,
    // Pattern output pins and their output enables
    output logic [15:0] PATTERN_OUTPUT_PIN,
    output logic [15:0] PATTERN_OUTPUT_OE
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0] port_a_direction_r;
    logic [7:0] port_b_direction_r;
    logic [7:0] pattern_output_mode_r;
    logic [7:0] pattern_trigger_control_r;
    logic [7:0] next_enable_low_groups_r;
    logic [7:0] next_enable_high_groups_r;
    logic [7:0] next_data_low_groups_r;
    logic [7:0] next_data_high_groups_r;
    logic [7:0] port_a_output_latch_r;
    logic [7:0] port_b_output_latch_r;
    logic [7:0] port_a_output_latch_nxt;
    logic [7:0] port_b_output_latch_nxt;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire logic [19:0] idx;
    wire logic lane0;
    wire logic wr_commit;
    wire logic same_low;
    wire logic same_high;
    wire logic sel_dir_a;
    wire logic sel_dir_b;
    wire logic sel_mode;
    wire logic sel_ctrl;
    wire logic sel_en_high;
    wire logic sel_en_low;
    wire logic sel_nd_a4;
    wire logic sel_nd_a5;
    wire logic sel_nd_a6;
    wire logic sel_nd_a7;
    wire logic sel_latch_a;
    wire logic sel_latch_b;
    wire logic [7:0] wdata;
    wire logic [7:0] rd_value;

    // Upper address bits beyond the 20-bit index are not looked at.
    assign idx = ADDRESS[`IDX_MSB:`IDX_LSB];
    assign lane0 = BYTEENABLE[0];
    assign wdata = WRITEDATA[7:0];

    assign same_low = (pattern_trigger_control_r[1:0] == pattern_trigger_control_r[3:2]);
    assign same_high = (pattern_trigger_control_r[5:4] == pattern_trigger_control_r[7:6]);

    assign sel_dir_a = (idx == `IDX_PORT_A_DIRECTION);
    assign sel_dir_b = (idx == `IDX_PORT_B_DIRECTION);
    assign sel_mode = (idx == `IDX_PATTERN_OUTPUT_MODE);
    assign sel_ctrl = (idx == `IDX_PATTERN_TRIGGER_CONTROL);
    assign sel_en_high = (idx == `IDX_NEXT_ENABLE_HIGH_GROUPS);
    assign sel_en_low = (idx == `IDX_NEXT_ENABLE_LOW_GROUPS);
    assign sel_nd_a4 = (idx == `IDX_NEXT_DATA_HIGH_GROUPS);
    assign sel_nd_a5 = (idx == `IDX_NEXT_DATA_LOW_GROUPS);
    assign sel_nd_a6 = (idx == `IDX_NEXT_DATA_HIGH_SPLIT);
    assign sel_nd_a7 = (idx == `IDX_NEXT_DATA_LOW_SPLIT);
    assign sel_latch_a = (idx == `IDX_PORT_A_OUTPUT_LATCH);
    assign sel_latch_b = (idx == `IDX_PORT_B_OUTPUT_LATCH);

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Direction registers are write-only and read as zero, like any
    // unmapped address.
    assign rd_value =
        sel_mode ? pattern_output_mode_r :
        sel_ctrl ? pattern_trigger_control_r :
        sel_en_high ? next_enable_high_groups_r :
        sel_en_low ? next_enable_low_groups_r :
        sel_nd_a5 ? (same_low ? next_data_low_groups_r :
                     {next_data_low_groups_r[7:4], `RESERVED_NIBBLE}) :
        sel_nd_a7 ? (same_low ? `RESERVED_BYTE :
                     {`RESERVED_NIBBLE, next_data_low_groups_r[3:0]}) :
        sel_nd_a4 ? (same_high ? next_data_high_groups_r :
                     {next_data_high_groups_r[7:4], `RESERVED_NIBBLE}) :
        sel_nd_a6 ? (same_high ? `RESERVED_BYTE :
                     {`RESERVED_NIBBLE, next_data_high_groups_r[3:0]}) :
        sel_latch_a ? port_a_output_latch_r :
        sel_latch_b ? port_b_output_latch_r :
        8'h00;

    avmm_front u_front (
        .clk(MCLK),
        .rst_n(RST_N),
        .read(READ),
        .write(WRITE),
        .rd_value(rd_value),
        .waitrequest(WAITREQUEST),
        .readdata(READDATA),
        .wr_commit(wr_commit)
    );

    wire logic wr_go;
    assign wr_go = wr_commit && lane0;

    // ****************************************************************
    // Per-group trigger handling
    // ****************************************************************
    wire logic [15:0] enable_all;
    wire logic [15:0] next_all;
    wire logic [15:0] load_all;

    assign enable_all = {next_enable_high_groups_r, next_enable_low_groups_r};
    assign next_all = {next_data_high_groups_r, next_data_low_groups_r};

    genvar g;
    generate
        for (g = 0; g < `GROUP_COUNT; g = g + 1) begin : grp
            // Group g owns outputs 4g to 4g+3, with its own trigger field.
            pattern_group u_group (
                .cm_a(CM_A),
                .cm_b(CM_B),
                .trig_sel(pattern_trigger_control_r[g*`TRIG_SEL_W +: `TRIG_SEL_W]),
                .non_overlap(pattern_output_mode_r[g]),
                .enable(enable_all[g*`GROUP_W +: `GROUP_W]),
                .next_data(next_all[g*`GROUP_W +: `GROUP_W]),
                .load(load_all[g*`GROUP_W +: `GROUP_W])
            );
        end
    endgenerate

    // ****************************************************************
    // Port latch next values
    // ****************************************************************
    // A trigger only touches enabled bits and a bus write only touches
    // disabled ones, so the two can never fight over a bit.
    always_comb begin
        port_a_output_latch_nxt = port_a_output_latch_r;
        port_b_output_latch_nxt = port_b_output_latch_r;
        if (wr_go && sel_latch_a) begin
            port_a_output_latch_nxt = (port_a_output_latch_r & next_enable_low_groups_r) |
                                      (wdata & ~next_enable_low_groups_r);
        end
        if (wr_go && sel_latch_b) begin
            port_b_output_latch_nxt = (port_b_output_latch_r & next_enable_high_groups_r) |
                                      (wdata & ~next_enable_high_groups_r);
        end
        port_a_output_latch_nxt = (port_a_output_latch_nxt & ~load_all[7:0]) |
                                  (next_data_low_groups_r & load_all[7:0]);
        port_b_output_latch_nxt = (port_b_output_latch_nxt & ~load_all[15:8]) |
                                  (next_data_high_groups_r & load_all[15:8]);
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            port_a_direction_r <= `RST_DIRECTION;
            port_b_direction_r <= `RST_DIRECTION;
            pattern_output_mode_r <= `RST_MODE;
            pattern_trigger_control_r <= `RST_TRIGGER_CONTROL;
            next_enable_low_groups_r <= `RST_NEXT_ENABLE;
            next_enable_high_groups_r <= `RST_NEXT_ENABLE;
            port_a_output_latch_r <= `RST_OUTPUT_LATCH;
            port_b_output_latch_r <= `RST_OUTPUT_LATCH;
        end else begin
            // The latch copy lands at the edge right after the trigger pulse.
            port_a_output_latch_r <= port_a_output_latch_nxt;
            port_b_output_latch_r <= port_b_output_latch_nxt;
            if (wr_go && sel_dir_a) begin
                port_a_direction_r <= wdata;
            end
            if (wr_go && sel_dir_b) begin
                port_b_direction_r <= wdata;
            end
            if (wr_go && sel_mode) begin
                // Upper mode bits have no function and hold at one.
                pattern_output_mode_r <= {`MODE_RESERVED_BITS, wdata[3:0]};
            end
            if (wr_go && sel_ctrl) begin
                pattern_trigger_control_r <= wdata;
            end
            if (wr_go && sel_en_low) begin
                next_enable_low_groups_r <= wdata;
            end
            if (wr_go && sel_en_high) begin
                next_enable_high_groups_r <= wdata;
            end
        end
    end

    // Next data writes steer by the trigger grouping at the moment of the
    // write; software should set trigger control before loading data.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            next_data_low_groups_r <= `RST_NEXT_DATA;
            next_data_high_groups_r <= `RST_NEXT_DATA;
        end else begin
            if (wr_go && sel_nd_a5) begin
                next_data_low_groups_r[7:4] <= wdata[7:4];
                if (same_low) begin
                    next_data_low_groups_r[3:0] <= wdata[3:0];
                end
            end
            if (wr_go && sel_nd_a7 && !same_low) begin
                next_data_low_groups_r[3:0] <= wdata[3:0];
            end
            if (wr_go && sel_nd_a4) begin
                next_data_high_groups_r[7:4] <= wdata[7:4];
                if (same_high) begin
                    next_data_high_groups_r[3:0] <= wdata[3:0];
                end
            end
            if (wr_go && sel_nd_a6 && !same_high) begin
                next_data_high_groups_r[3:0] <= wdata[3:0];
            end
        end
    end

    // ****************************************************************
    // Pins
    // ****************************************************************
    // A pin only drives once software has set its direction bit.
    assign PATTERN_OUTPUT_PIN = {port_b_output_latch_r, port_a_output_latch_r};
    assign PATTERN_OUTPUT_OE = {port_b_direction_r, port_a_direction_r};

endmodule
`default_nettype wire

// ---- tb/timer_match_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module timer_match_model (
    // Clock
    input wire logic clk,
    // Compare match pulses of timer channels 0 to 2
    output var logic [2:0] cm_a,
    output var logic [2:0] cm_b
);
    // ****************************************************************
    // Compare match source
    // ****************************************************************
    initial begin
        cm_a = 3'h0;
        cm_b = 3'h0;
    end

    // A match lasts one clock, so a held level can never copy twice.
    task automatic fire(input int ch, input bit on_b);
        if (on_b) begin
            cm_b[ch] <= 1'b1;
        end else begin
            cm_a[ch] <= 1'b1;
        end
        @(posedge clk);
        cm_a <= 3'h0;
        cm_b <= 3'h0;
    endtask
endmodule
`default_nettype wire

// ---- tb/timing_pattern_unit_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pattern_unit_regs.svh"

module timing_pattern_unit_asserts (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Register bus
    input wire logic [31:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [31:0] READDATA,
    input wire logic WAITREQUEST,
    // Compare matches and pins
    input wire logic [2:0] CM_A,
    input wire logic [2:0] CM_B,
    input wire logic [15:0] PATTERN_OUTPUT_PIN,
    input wire logic [15:0] PATTERN_OUTPUT_OE
);
    // ****************************************************************
    // Port checks
    // ****************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    wire wr_done = WRITE && !WAITREQUEST && BYTEENABLE[0];

    AST_RESET_OUTPUTS: assert property ($rose(RST_N) |->
        PATTERN_OUTPUT_PIN == 16'h0000 && PATTERN_OUTPUT_OE == 16'h0000)
        else $error("pins not cleared by reset");
    AST_ACK_AFTER_TAKE: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
        else $error("request not answered in one cycle");
    AST_ACK_ONE_CYCLE: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("answer held longer than one cycle");
    AST_NO_ACK_UNASKED: assert property (!WAITREQUEST |-> (READ || WRITE))
        else $error("answer without a request");
    AST_READ_UPPER_ZERO: assert property (READDATA[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    AST_PIN_HOLDS: assert property (CM_A == 3'h0 && CM_B == 3'h0 &&
        !(WRITE && !WAITREQUEST) |=> $stable(PATTERN_OUTPUT_PIN))
        else $error("pin moved without trigger or write");
    AST_OE_ONLY_BY_WRITE: assert property (!(WRITE && !WAITREQUEST) |=>
        $stable(PATTERN_OUTPUT_OE)) else $error("direction moved without write");
    AST_DIR_A_WRITE: assert property (wr_done &&
        ADDRESS[21:2] == `IDX_PORT_A_DIRECTION |=>
        PATTERN_OUTPUT_OE[7:0] == $past(WRITEDATA[7:0])) else $error("port A direction");
    AST_DIR_B_WRITE: assert property (wr_done &&
        ADDRESS[21:2] == `IDX_PORT_B_DIRECTION |=>
        PATTERN_OUTPUT_OE[15:8] == $past(WRITEDATA[7:0])) else $error("port B direction");

    COV_WRITE: cover property (wr_done);
    COV_READ: cover property (READ && !WAITREQUEST && READDATA != 32'h0);
    COV_TRIG_MOVE: cover property (CM_A != 3'h0 ##1 $changed(PATTERN_OUTPUT_PIN));
endmodule

bind timing_pattern_unit timing_pattern_unit_asserts chk (.MCLK(MCLK), .RST_N(RST_N),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .BYTEENABLE(BYTEENABLE),
    .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .CM_A(CM_A),
    .CM_B(CM_B), .PATTERN_OUTPUT_PIN(PATTERN_OUTPUT_PIN), .PATTERN_OUTPUT_OE(PATTERN_OUTPUT_OE));
`default_nettype wire

// ---- tb/timing_pattern_unit_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pattern_unit_regs.svh"

module timing_pattern_unit_tb_top;
    // ****************************************************************
    // Stimulus, reference model and checks
    // ****************************************************************
    logic MCLK;
    logic RST_N;
    logic [31:0] ADDRESS;
    logic READ;
    logic WRITE;
    logic [3:0] BYTEENABLE;
    logic [31:0] WRITEDATA;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    logic [2:0] CM_A;
    logic [2:0] CM_B;
    logic [15:0] PATTERN_OUTPUT_PIN;
    logic [15:0] PATTERN_OUTPUT_OE;
    logic [31:0] seed = 32'h1C93;
    logic [31:0] r;
    int n_fail = 0;
    int cmp_count = 0;
    logic [7:0] dir_a, dir_b, mode, pattern_trigger_control, en_a, en_b, nd_a, nd_b, pa, pb;
    logic [19:0] idxs [13] = '{`IDX_PORT_A_DIRECTION, `IDX_PORT_B_DIRECTION,
        `IDX_PATTERN_OUTPUT_MODE, `IDX_PATTERN_TRIGGER_CONTROL, `IDX_NEXT_ENABLE_HIGH_GROUPS,
        `IDX_NEXT_ENABLE_LOW_GROUPS, `IDX_NEXT_DATA_HIGH_GROUPS, `IDX_NEXT_DATA_LOW_GROUPS,
        `IDX_NEXT_DATA_HIGH_SPLIT, `IDX_NEXT_DATA_LOW_SPLIT, `IDX_PORT_A_OUTPUT_LATCH,
        `IDX_PORT_B_OUTPUT_LATCH, 20'h12345};

    timing_pattern_unit DUT (.MCLK(MCLK), .RST_N(RST_N), .ADDRESS(ADDRESS), .READ(READ),
        .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .CM_A(CM_A), .CM_B(CM_B),
        .PATTERN_OUTPUT_PIN(PATTERN_OUTPUT_PIN), .PATTERN_OUTPUT_OE(PATTERN_OUTPUT_OE));
    timer_match_model tmr (.clk(MCLK), .cm_a(CM_A), .cm_b(CM_B));

    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic m_reset();
        {dir_a, dir_b, en_a, en_b, nd_a, nd_b, pa, pb} = 64'h0;
        mode = 8'hF0;
        pattern_trigger_control = 8'hFF;
    endtask

    // The split layout is judged on the trigger fields as they stand before the access.
    function automatic logic [7:0] m_read(input logic [19:0] i);
        logic sa, sb;
        sa = pattern_trigger_control[1:0] == pattern_trigger_control[3:2];
        sb = pattern_trigger_control[5:4] == pattern_trigger_control[7:6];
        case (i)
            `IDX_PATTERN_OUTPUT_MODE: return {4'hF, mode[3:0]};
            `IDX_PATTERN_TRIGGER_CONTROL: return pattern_trigger_control;
            `IDX_NEXT_ENABLE_HIGH_GROUPS: return en_b;
            `IDX_NEXT_ENABLE_LOW_GROUPS: return en_a;
            `IDX_NEXT_DATA_HIGH_GROUPS: return sb ? nd_b : {nd_b[7:4], 4'hF};
            `IDX_NEXT_DATA_LOW_GROUPS: return sa ? nd_a : {nd_a[7:4], 4'hF};
            `IDX_NEXT_DATA_HIGH_SPLIT: return sb ? 8'hFF : {4'hF, nd_b[3:0]};
            `IDX_NEXT_DATA_LOW_SPLIT: return sa ? 8'hFF : {4'hF, nd_a[3:0]};
            `IDX_PORT_A_OUTPUT_LATCH: return pa;
            `IDX_PORT_B_OUTPUT_LATCH: return pb;
            default: return 8'h00;
        endcase
    endfunction

    task automatic m_write(input logic [19:0] i, input logic [7:0] d);
        logic sa, sb;
        sa = pattern_trigger_control[1:0] == pattern_trigger_control[3:2];
        sb = pattern_trigger_control[5:4] == pattern_trigger_control[7:6];
        case (i)
            `IDX_PORT_A_DIRECTION: dir_a = d;
            `IDX_PORT_B_DIRECTION: dir_b = d;
            `IDX_PATTERN_OUTPUT_MODE: mode = {4'hF, d[3:0]};
            `IDX_PATTERN_TRIGGER_CONTROL: pattern_trigger_control = d;
            `IDX_NEXT_ENABLE_HIGH_GROUPS: en_b = d;
            `IDX_NEXT_ENABLE_LOW_GROUPS: en_a = d;
            `IDX_NEXT_DATA_HIGH_GROUPS: nd_b = sb ? d : {d[7:4], nd_b[3:0]};
            `IDX_NEXT_DATA_LOW_GROUPS: nd_a = sa ? d : {d[7:4], nd_a[3:0]};
            `IDX_NEXT_DATA_HIGH_SPLIT: nd_b = sb ? nd_b : {nd_b[7:4], d[3:0]};
            `IDX_NEXT_DATA_LOW_SPLIT: nd_a = sa ? nd_a : {nd_a[7:4], d[3:0]};
            `IDX_PORT_A_OUTPUT_LATCH: pa = (pa & en_a) | (d & ~en_a);
            `IDX_PORT_B_OUTPUT_LATCH: pb = (pb & en_b) | (d & ~en_b);
            default: ;
        endcase
    endtask

    task automatic m_trig(input int ch, input bit onb);
        logic [15:0] lat;
        logic [15:0] m;
        logic [1:0] s;
        lat = {pb, pa};
        for (int g = 0; g < 4; g++) begin
            s = pattern_trigger_control[2 * g +: 2];
            m = {en_b, en_a} & (16'h000F << (4 * g));
            if ((s == 2'b11 ? 2'd2 : s) == ch[1:0]) begin
                if (mode[g] && !onb) lat = lat | (m & {nd_b, nd_a});
                else if (mode[g]) lat = lat & ~(m & ~{nd_b, nd_a});
                else if (!onb) lat = (lat & ~m) | ({nd_b, nd_a} & m);
            end
        end
        {pb, pa} = lat;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Upper address bits are random so every access also tests that they are ignored.
    task automatic bus(input bit wr, input logic [19:0] idx, input logic [7:0] d, input bit keep);
        int n;
        logic [31:0] r0;
        logic be0;
        n = 0;
        r0 = rnd();
        be0 = keep | r0[0] | r0[1];
        ADDRESS <= {r0[31:22], idx, 2'b00};
        BYTEENABLE <= {r0[4:2], be0};
        WRITEDATA <= {r0[29:6], d};
        READ <= !wr;
        WRITE <= wr;
        do begin
            @(posedge MCLK);
            n++;
        end while (WAITREQUEST !== 1'b0 && n < 40);
        chk({31'h0, WAITREQUEST}, 32'h0);
        if (!wr) chk(READDATA, {24'h0, m_read(idx)});
        else if (be0) m_write(idx, d);
        READ <= 1'b0;
        WRITE <= 1'b0;
        @(posedge MCLK);
    endtask

    task automatic pins();
        chk({PATTERN_OUTPUT_OE, PATTERN_OUTPUT_PIN}, {dir_b, dir_a, pb, pa});
    endtask

    task automatic trig(input int ch, input bit onb);
        tmr.fire(ch, onb);
        m_trig(ch, onb);
        @(posedge MCLK);
        pins();
    endtask

    task automatic read_all();
        for (int i = 0; i < 13; i++) bus(1'b0, idxs[i], 8'h00, 1'b1);
        pins();
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge MCLK);
        n_fail++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
        complete_run();
    end

    initial begin
        RST_N = 1'b0;
        ADDRESS = 32'h0;
        READ = 1'b0;
        WRITE = 1'b0;
        BYTEENABLE = 4'h0;
        WRITEDATA = 32'h0;
        m_reset();
        repeat (10) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (2) @(posedge MCLK);
        read_all();
        $display("test reset values done");
        bus(1'b1, `IDX_PORT_A_DIRECTION, 8'hFF, 1'b1);
        bus(1'b1, `IDX_PORT_B_DIRECTION, 8'hFF, 1'b1);
        read_all();
        $display("test direction done");
        for (int k = 0; k < 12; k++) begin
            r = rnd();
            bus(1'b1, `IDX_PATTERN_TRIGGER_CONTROL, k[0] ? r[7:0] : {4{r[1:0]}}, 1'b1);
            bus(1'b1, `IDX_PATTERN_OUTPUT_MODE, k[1] ? r[15:8] : 8'h00, 1'b1);
            for (int j = 4; j < 12; j++) begin
                r = rnd();
                bus(1'b1, idxs[j], r[7:0], 1'b0);
            end
            read_all();
            for (int c = 0; c < 3; c++) begin
                trig(c, 1'b0);
                trig(c, 1'b1);
            end
        end
        $display("test pattern groups done");
        RST_N <= 1'b0;
        repeat (2) @(posedge MCLK);
        RST_N <= 1'b1;
        m_reset();
        repeat (2) @(posedge MCLK);
        read_all();
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
`default_nettype wire
